// >>> core/snp_packer.sv
// Stream master: packs 12-bit real or complex samples through a FIFO onto the stream
`timescale 1ns/100ps
`include "snp_params.svh"

module snp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  wire do_wr;
  wire do_rd;

  // Honest flags: full stalls the packer, empty drops valid
  assign in_ready = (count != CNT_W'(DEPTH));
  assign out_valid = (count != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  // Head word only moves on acceptance, so data stays put while waiting
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (do_wr && !do_rd)
    begin
      next_count = count + 1'b1;
    end
    else if (do_rd && !do_wr)
    begin
      next_count = count - 1'b1;
    end
  end

  // Storage carries no reset: only words below count are ever read
  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      count <= next_count;
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end
endmodule

module snp_packer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_complex,
  input wire logic cfg_signed,
  input wire logic [`SNP_VLEN_W-1:0] cfg_vec_len,
  input wire logic usr_valid,
  output logic usr_ready,
  input wire snp_pkg::snp_sample_t usr_re,
  input wire snp_pkg::snp_sample_t usr_im,
  snp_if.mst stream
);
  localparam int FIFO_W = `SNP_DATA_W + `SNP_KEEP_W + 1;

  // Pads one sample to a byte-aligned unit; the sample is already atomic
  function automatic snp_pkg::snp_unit_t pad_unit(input snp_pkg::snp_sample_t s, input logic sgn);
    pad_unit = {{`SNP_PAD_W{sgn & s[`SNP_N-1]}}, s};
  endfunction

  snp_pkg::snp_lane_e lane;
  snp_pkg::snp_lane_e next_lane;
  snp_pkg::snp_unit_t hold;
  logic [`SNP_VLEN_W-1:0] elem_cnt;
  logic [`SNP_VLEN_W-1:0] next_elem_cnt;

  wire fifo_in_ready;
  wire take;
  wire packetized;
  wire last_elem;
  wire push;
  wire alone;
  snp_pkg::snp_unit_t unit_re;
  snp_pkg::snp_unit_t unit_im;
  snp_pkg::snp_data_t beat_data;
  snp_pkg::snp_keep_t beat_keep;
  wire beat_last;
  wire [FIFO_W-1:0] fifo_in;
  wire [FIFO_W-1:0] fifo_out;

  // Samples stall as soon as the FIFO fills
  assign usr_ready = fifo_in_ready;
  assign take = usr_valid && fifo_in_ready;

  // Vector length zero means a plain scalar stream with no packets
  assign packetized = (cfg_vec_len != '0);
  assign last_elem = packetized && (elem_cnt == cfg_vec_len - 1'b1);

  // Every value uses the same padded unit, whatever its place in the vector
  assign unit_re = pad_unit(usr_re, cfg_signed);
  assign unit_im = pad_unit(usr_im, cfg_signed);

  // A complex value fills both lanes at once; a real one needs a partner
  // unless it closes the vector
  assign push = take && (cfg_complex || (lane == snp_pkg::SNP_LANE_HELD) || last_elem);
  assign alone = !cfg_complex && (lane == snp_pkg::SNP_LANE_EMPTY);

  // Lane 0 is the low half; real part first, imaginary in the next lane
  assign beat_data = cfg_complex ? {unit_im, unit_re} :
    alone ? {{`SNP_UNIT_W{1'b0}}, unit_re} :
    {unit_re, hold};

  // Only a short final beat clears keep bits, and it always carries last
  assign beat_keep = alone ? `SNP_KEEP_LOW : `SNP_KEEP_ALL;
  // Length one raises last each beat; length zero never does
  assign beat_last = last_elem;

  assign fifo_in = {beat_last, beat_keep, beat_data};

  always_comb
  begin
    next_lane = lane;
    if (push)
    begin
      next_lane = snp_pkg::SNP_LANE_EMPTY;
    end
    else if (take && alone)
    begin
      next_lane = snp_pkg::SNP_LANE_HELD;
    end
  end

  always_comb
  begin
    next_elem_cnt = elem_cnt;
    if (take)
    begin
      next_elem_cnt = (last_elem || !packetized) ? '0 : elem_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lane <= snp_pkg::SNP_LANE_EMPTY;
      elem_cnt <= '0;
      hold <= '0;
    end
    else
    begin
      lane <= next_lane;
      elem_cnt <= next_elem_cnt;
      if (take && alone && !push)
      begin
        hold <= unit_re;
      end
    end
  end

  // The FIFO decouples the sample source from stream back-pressure
  snp_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(`SNP_FIFO_DEPTH)
  ) snp_fifo_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(stream.tvalid),
    .out_ready(stream.tready),
    .out_data(fifo_out)
  );

  assign stream.tdata = fifo_out[`SNP_DATA_W-1:0];
  assign stream.tkeep = fifo_out[`SNP_DATA_W+`SNP_KEEP_W-1:`SNP_DATA_W];
  // Strobe simply follows keep so no byte is ever marked as position only
  assign stream.tstrb = fifo_out[`SNP_DATA_W+`SNP_KEEP_W-1:`SNP_DATA_W];
  assign stream.tlast = fifo_out[FIFO_W-1];
endmodule

// >>> core/snp_params.svh
// Constants for the numeric stream packer and unpacker
// Notes on behaviour
// - Both ends carry ready back-pressure
// - Null bytes only mark a packet remainder
// - Remainders use keep; strobe is never used
// - All values share one unit width
// - Each unit padded to whole bytes
// - Complex: real unit first, imaginary second
// - A real value uses one unit
// - Receiver ignores pad bits above the width
// - Sender pads with zeros or sign copies
// - Wide data carries several units per beat
// - Fill lanes across data, then next beats
// - Never join partial fields; pad each unit alone
// - Each unit starts on a byte boundary
// - Unpacketized scalars keep last low
// - One-element vectors raise last every beat
// - Narrow channel: real beat, then imaginary beat
// - Wide channel: whole complex value per beat
// - Cleared keep bits only with last
`ifndef SNP_PARAMS_SVH
`define SNP_PARAMS_SVH
`define SNP_N 12
`define SNP_PAD_W 4
`define SNP_UNIT_W 16
`define SNP_DATA_W 32
`define SNP_KEEP_W 4
`define SNP_LANES 2
`define SNP_FIFO_DEPTH 32
`define SNP_VLEN_W 8
`define SNP_KEEP_ALL 4'hF
`define SNP_KEEP_LOW 4'h3
`define SNP_KEEP_HI_BIT 2
`endif

// >>> core/snp_pkg.sv
// Types shared by both ends of the numeric stream
`include "snp_params.svh"
package snp_pkg;
  typedef logic [`SNP_N-1:0] snp_sample_t;
  typedef logic [`SNP_UNIT_W-1:0] snp_unit_t;
  typedef logic [`SNP_DATA_W-1:0] snp_data_t;
  typedef logic [`SNP_KEEP_W-1:0] snp_keep_t;
  typedef enum logic {SNP_LANE_EMPTY, SNP_LANE_HELD} snp_lane_e;
  typedef enum logic [1:0] {SNP_RX_EMPTY, SNP_RX_FIRST, SNP_RX_SECOND} snp_rx_e;
endpackage

// >>> core/snp_if.sv
// Stream channel between the packer and the unpacker
`timescale 1ns/100ps
`include "snp_params.svh"
interface snp_if;
  logic tvalid;
  logic tready;
  logic [`SNP_DATA_W-1:0] tdata;
  logic [`SNP_KEEP_W-1:0] tkeep;
  logic [`SNP_KEEP_W-1:0] tstrb;
  logic tlast;
  modport mst (output tvalid, input tready, output tdata, output tkeep, output tstrb, output tlast);
  modport slv (input tvalid, output tready, input tdata, input tkeep, input tstrb, input tlast);
endinterface

// >>> core/snp_unpacker.sv
// Stream slave: unpacks beats into 12-bit real or complex samples
`timescale 1ns/100ps
`include "snp_params.svh"
module snp_unpacker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_complex,
  output logic out_valid,
  input wire logic out_ready,
  output snp_pkg::snp_sample_t out_re,
  output snp_pkg::snp_sample_t out_im,
  output logic out_last,
  snp_if.slv stream
);
  snp_pkg::snp_rx_e state;
  snp_pkg::snp_rx_e next_state;
  snp_pkg::snp_data_t beat;
  logic beat_last;
  logic lane1_kept;

  wire is_final;
  wire out_take;
  wire beat_take;

  // Strobe is ignored; a cleared upper keep half marks a lone last unit
  assign is_final = (state == snp_pkg::SNP_RX_SECOND) ||
    ((state == snp_pkg::SNP_RX_FIRST) && (cfg_complex || !lane1_kept));
  assign out_valid = (state != snp_pkg::SNP_RX_EMPTY);
  assign out_take = out_valid && out_ready;
  // Ready reopens in the cycle the last unit of the held beat leaves
  assign stream.tready = (state == snp_pkg::SNP_RX_EMPTY) || (out_take && is_final);
  assign beat_take = stream.tvalid && stream.tready;

  // Only the low N bits of each lane are used; pad bits are dropped
  assign out_re = beat[`SNP_N-1:0];
  assign out_im = beat[`SNP_UNIT_W+`SNP_N-1:`SNP_UNIT_W];
  assign out_last = beat_last && is_final;

  always_comb
  begin
    case (state)
      snp_pkg::SNP_RX_EMPTY:
        next_state = beat_take ? snp_pkg::SNP_RX_FIRST : snp_pkg::SNP_RX_EMPTY;
      snp_pkg::SNP_RX_FIRST:
        if (out_take && is_final)
        begin
          next_state = beat_take ? snp_pkg::SNP_RX_FIRST : snp_pkg::SNP_RX_EMPTY;
        end
        else
        begin
          next_state = out_take ? snp_pkg::SNP_RX_SECOND : snp_pkg::SNP_RX_FIRST;
        end
      snp_pkg::SNP_RX_SECOND:
        if (out_take)
        begin
          next_state = beat_take ? snp_pkg::SNP_RX_FIRST : snp_pkg::SNP_RX_EMPTY;
        end
        else
        begin
          next_state = snp_pkg::SNP_RX_SECOND;
        end
      default:
        next_state = snp_pkg::SNP_RX_EMPTY;
    endcase
  end

  // Real beats shift lane 1 down so outputs stay plain flop slices
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= snp_pkg::SNP_RX_EMPTY;
      beat <= '0;
      beat_last <= 1'b0;
      lane1_kept <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (beat_take)
      begin
        beat <= stream.tdata;
        beat_last <= stream.tlast;
        lane1_kept <= stream.tkeep[`SNP_KEEP_HI_BIT];
      end
      else if (out_take && !is_final)
      begin
        beat <= {{`SNP_UNIT_W{1'b0}}, beat[`SNP_DATA_W-1:`SNP_UNIT_W]};
      end
    end
  end
endmodule

// >>> bench/snp_checker.sv
// Concurrent checks on the stream link between packer and unpacker
`timescale 1ns/100ps
`include "snp_params.svh"
module snp_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tvalid,
  input wire logic tready,
  input wire logic [`SNP_DATA_W-1:0] tdata,
  input wire logic [`SNP_KEEP_W-1:0] tkeep,
  input wire logic [`SNP_KEEP_W-1:0] tstrb,
  input wire logic tlast
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence stall_s;
    tvalid && !tready;
  endsequence
  sequence held_s;
    tvalid && $stable(tdata) && $stable(tkeep) && $stable(tlast);
  endsequence
  beat_hold_a: assert property (stall_s |=> held_s)
    else $error("stalled beat changed");
  valid_drop_a: assert property ($fell(tvalid) |-> $past(tready))
    else $error("valid dropped without acceptance");
  strb_copy_a: assert property (tvalid |-> tstrb == tkeep)
    else $error("strobe differs from keep");
  keep_last_a: assert property (tvalid && tkeep != `SNP_KEEP_ALL |-> tlast)
    else $error("partial keep without last");
  keep_form_a: assert property (tvalid |-> tkeep == `SNP_KEEP_ALL || tkeep == `SNP_KEEP_LOW)
    else $error("keep has leading or inner null bytes");
  pad_low_a: assert property (tvalid |-> tdata[15:12] == 4'h0 || tdata[15:12] == {4{tdata[11]}})
    else $error("lane0 pad bits not an extension");
  pad_high_a: assert property (tvalid && tkeep[2] |-> tdata[31:28] == 4'h0 || tdata[31:28] == {4{tdata[27]}})
    else $error("lane1 pad bits not an extension");
  rem_zero_a: assert property (tvalid && !tkeep[2] |-> tdata[31:16] == 16'h0000)
    else $error("remainder lane not zero");
endmodule

// >>> bench/snp_packer_bench.sv
// Self-checking bench joining packer and unpacker across the stream link
`timescale 1ns/100ps
`include "snp_params.svh"
module snp_packer_bench;
  typedef struct {logic cx; logic sg; logic [7:0] vl; int n; int nb;} snp_row_s;
  snp_row_s rows [6] = '{'{0, 0, 8'h00, 6, 3}, '{0, 1, 8'h01, 3, 3}, '{0, 0, 8'h03, 6, 4},
    '{1, 1, 8'h01, 4, 4}, '{1, 0, 8'h04, 8, 8}, '{0, 1, 8'h02, 4, 2}};
  logic sys_clk = 0;
  logic rst_n = 0;
  logic cfg_complex = 0;
  logic cfg_signed = 0;
  logic [7:0] cfg_vec_len = 8'h00;
  logic usr_valid = 0;
  logic out_ready = 1;
  logic usr_ready, out_valid, out_last;
  snp_pkg::snp_sample_t usr_re = 12'h000, usr_im = 12'h000, out_re, out_im;
  int fail_count = 0, tests_run = 0, beats = 0;
  logic [24:0] e;
  logic [24:0] oq [$];
  logic [11:0] wq [$];
  snp_if snp_if_i ();
  snp_packer snp_packer_i (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_complex(cfg_complex), .cfg_signed(cfg_signed),
    .cfg_vec_len(cfg_vec_len), .usr_valid(usr_valid), .usr_ready(usr_ready), .usr_re(usr_re), .usr_im(usr_im),
    .stream(snp_if_i));
  snp_unpacker snp_unpacker_i (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_complex(cfg_complex), .out_valid(out_valid),
    .out_ready(out_ready), .out_re(out_re), .out_im(out_im), .out_last(out_last), .stream(snp_if_i));
  snp_checker snp_checker_i (.sys_clk(sys_clk), .rst_n(rst_n), .tvalid(snp_if_i.tvalid), .tready(snp_if_i.tready),
    .tdata(snp_if_i.tdata), .tkeep(snp_if_i.tkeep), .tstrb(snp_if_i.tstrb), .tlast(snp_if_i.tlast));
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Expectations are queued before the edge that takes the sample
  task automatic send(input int i, input logic last);
    usr_valid = 1;
    usr_re = 12'(i * 12'h29B + 12'h7A5);
    usr_im = ~usr_re;
    while (!usr_ready)
      @(negedge sys_clk);
    oq.push_back({last, usr_im, usr_re});
    wq.push_back(usr_re);
    if (cfg_complex)
      wq.push_back(usr_im);
    @(negedge sys_clk);
  endtask
  // Output side stalls every other cycle while draining
  task automatic drain;
    repeat (200)
      if (oq.size() != 0)
      begin
        out_ready = !out_ready;
        @(negedge sys_clk);
      end
    out_ready = 1;
    chk("drained", 0, oq.size());
  endtask
  always @(posedge sys_clk)
  begin
    if (rst_n && snp_if_i.tvalid && snp_if_i.tready)
    begin
      beats++;
      chk("lane0", {20'h0, wq.pop_front()}, {20'h0, snp_if_i.tdata[11:0]});
      chk("pad0", {28'h0, cfg_signed ? {4{snp_if_i.tdata[11]}} : 4'h0}, {28'h0, snp_if_i.tdata[15:12]});
      if (snp_if_i.tkeep[2])
      begin
        chk("lane1", {20'h0, wq.pop_front()}, {20'h0, snp_if_i.tdata[27:16]});
        chk("pad1", {28'h0, cfg_signed ? {4{snp_if_i.tdata[27]}} : 4'h0}, {28'h0, snp_if_i.tdata[31:28]});
      end
    end
    if (rst_n && out_valid && out_ready)
    begin
      e = oq.pop_front();
      chk("out_re_last", {19'h0, e[24], e[11:0]}, {19'h0, out_last, out_re});
      if (cfg_complex)
        chk("out_im", {20'h0, e[23:12]}, {20'h0, out_im});
    end
  end
  initial
  begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1;
    for (int r = 0; r < 6; r++)
    begin
      cfg_complex = rows[r].cx;
      cfg_signed = rows[r].sg;
      cfg_vec_len = rows[r].vl;
      beats = 0;
      for (int i = 0; i < rows[r].n; i++)
        send(i, rows[r].vl != 0 && (i % rows[r].vl) == rows[r].vl - 1);
      usr_valid = 0;
      drain();
      chk("beats", rows[r].nb, beats);
    end
    // FIFO of 32 beats plus one beat held in the unpacker
    cfg_complex = 1;
    cfg_vec_len = 8'h00;
    out_ready = 0;
    for (int k = 0; k < 33; k++)
      send(k, 0);
    repeat (3) @(negedge sys_clk);
    chk("full", 0, usr_ready);
    usr_valid = 0;
    drain();
    send(1, 0);
    send(2, 0);
    rst_n = 0;
    @(negedge sys_clk);
    chk("rst_state", 4'h6, {snp_if_i.tvalid, usr_ready, snp_if_i.tready, out_valid});
    oq.delete();
    wq.delete();
    usr_valid = 0;
    @(negedge sys_clk);
    rst_n = 1;
    send(3, 0);
    usr_valid = 0;
    drain();
    stop_test();
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end
endmodule
